// file: rtl/bcl_map.svh
// offsets, field positions, reset values and counts of the configuration loader
`ifndef BCL_MAP_SVH
`define BCL_MAP_SVH
`define BCL_OFF_CTRL 8'h00
`define BCL_OFF_STATUS 8'h04
`define BCL_OFF_COUNT 8'h08
`define BCL_OFF_LENGTH 8'h0c
`define BCL_OFF_WSEL 8'h10
`define BCL_OFF_WDATA 8'h14
`define BCL_CTRL_START 0
`define BCL_CTRL_RST_LATE 1
`define BCL_CTRL_DONE_LATE 2
`define BCL_CTRL_PULLUP 3
`define BCL_CTRL_CMOS 4
`define BCL_CTRL_OSC 5
`define BCL_CTRL_W 6
`define BCL_CTRL_RESET 6'h00
`define BCL_FRAME_LEN 75
`define BCL_FRAME_CNT 197
`define BCL_K 4
`define BCL_STOP_BITS 3
`define BCL_PRE_W 12
`define BCL_PRE_CODE 12'hff2
`define BCL_LEN_W 24
`define BCL_SU_EARLY 3'h1
`define BCL_SU_IO 3'h2
`define BCL_SU_LATE 3'h3
`define BCL_MODE_MSER 3'h0
`define BCL_MODE_MUP 3'h1
`define BCL_MODE_MDN 3'h3
`define BCL_MODE_PER 3'h5
`define BCL_MODE_SSER 3'h7
`define BCL_ADDR_UP_START 16'h0000
`define BCL_ADDR_DN_START 16'hffff
`endif

// file: rtl/bcl_pkg.sv
// types shared by the configuration loader modules
package bcl_pkg;
    typedef logic [7:0] bcl_addr_t;
    typedef enum logic [7:0] {
        BCL_IDLE = 8'h01,
        BCL_PRE = 8'h02,
        BCL_LEN = 8'h04,
        BCL_FRM = 8'h08,
        BCL_PASS = 8'h10,
        BCL_SU = 8'h20,
        BCL_RUN = 8'h40,
        BCL_ERR = 8'h80
    } bcl_state_e;
endpackage

// file: rtl/bcl_mem_if.sv
// write and read port between the loader and its configuration memory
interface bcl_mem_if #(parameter int W = 71, parameter int AW = 8);
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [W-1:0] wr_data;
    logic [AW-1:0] rd_addr;
    logic [W-1:0] rd_data;
    modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// file: rtl/bcl_cfg_mem.sv
// configuration memory, one word per frame, registered read
module bcl_cfg_mem #(
    parameter int W = 71,
    parameter int D = 197,
    parameter int AW = 8
) (
    input wire logic clk,
    input wire logic nrst,
    bcl_mem_if.mem port
);
    logic [W-1:0] mem_ff [D];
    logic [W-1:0] rd_ff;

    always_ff @(posedge clk) begin
        if (port.wr_en && (int'(port.wr_addr) < D)) begin
            mem_ff[port.wr_addr] <= port.wr_data;
        end
    end

    // out-of-range read returns zero rather than an undefined word
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_ff <= '0;
        end else if (int'(port.rd_addr) < D) begin
            rd_ff <= mem_ff[port.rd_addr];
        end else begin
            rd_ff <= '0;
        end
    end

    assign port.rd_data = rd_ff;
endmodule

// file: rtl/bcl_loader.sv
// configuration bitstream loader and start-up sequencer with apb registers
//
// Chosen here: the APB register port and the address map.
`include "bcl_map.svh"
module bcl_loader
    import bcl_pkg::*;
#(
    parameter int FRAME_LEN = `BCL_FRAME_LEN,
    parameter int FRAME_CNT = `BCL_FRAME_CNT,
    parameter int K = `BCL_K
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire bcl_pkg::bcl_addr_t paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cfg_clock,
    input wire logic cfg_din,
    input wire logic [7:0] cfg_data,
    input wire logic mode_sel_0,
    input wire logic mode_sel_1,
    input wire logic mode_sel_2,
    output logic cfg_dout,
    output logic [15:0] prom_addr,
    output logic high_during_cfg_o,
    output logic high_during_cfg_oe,
    output logic low_during_cfg_o,
    output logic low_during_cfg_oe,
    input wire logic done_reprogram_pin_i,
    output logic done_reprogram_pin_o,
    output logic done_reprogram_pin_oe,
    output logic done_pullup_en,
    input wire logic init_pin_i,
    output logic init_pin_o,
    output logic init_pin_oe,
    output logic user_rst_n,
    output logic io_enable,
    output logic cmos_threshold,
    output logic osc_run,
    output logic osc_connect
);
    import bcl_pkg::*;

    localparam int W = FRAME_LEN - 1 - `BCL_STOP_BITS;
    localparam int AW = $clog2(FRAME_CNT);
    localparam int FBW = $clog2(FRAME_LEN);
    localparam logic [FBW-1:0] FB_LAST = FBW'(FRAME_LEN - 1);
    localparam logic [FBW-1:0] FB_DLAST = FBW'(W);
    localparam logic [FBW-1:0] FB_STOP = FBW'(FRAME_LEN - `BCL_STOP_BITS);
    localparam logic [AW-1:0] FI_LAST = AW'(FRAME_CNT - 1);
    localparam logic [2:0] SU_END = (K > 3) ? 3'(K) : `BCL_SU_LATE;

    generate
        if (W < 32 || FRAME_CNT < 2 || K < 2 || K > 4) begin : g_bad_param
            $error("bcl_loader: unsupported frame length, frame count or K");
        end
    endgenerate

    function automatic logic [2:0] reg_idx(input bcl_addr_t a);
        if (a == `BCL_OFF_CTRL) begin
            reg_idx = 3'h0;
        end else if (a == `BCL_OFF_STATUS) begin
            reg_idx = 3'h1;
        end else if (a == `BCL_OFF_COUNT) begin
            reg_idx = 3'h2;
        end else if (a == `BCL_OFF_LENGTH) begin
            reg_idx = 3'h3;
        end else if (a == `BCL_OFF_WSEL) begin
            reg_idx = 3'h4;
        end else if (a == `BCL_OFF_WDATA) begin
            reg_idx = 3'h5;
        end else begin
            reg_idx = 3'h7;
        end
    endfunction

    function automatic logic is_byte_mode(input logic [2:0] m);
        is_byte_mode = (m == `BCL_MODE_MUP) || (m == `BCL_MODE_MDN) || (m == `BCL_MODE_PER);
    endfunction

    bcl_mem_if #(.W(W), .AW(AW)) mem_port ();
    bcl_cfg_mem #(.W(W), .D(FRAME_CNT), .AW(AW)) u_mem (
        .clk(clk),
        .nrst(nrst),
        .port(mem_port.mem)
    );

    // pin inputs pass two flops; only the second stage is read
    logic [14:0] s1_ff, s2_ff;
    logic lclk_prev_ff;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_ff <= '0;
            s2_ff <= '0;
            lclk_prev_ff <= 1'b0;
        end else begin
            s1_ff <= {cfg_clock, cfg_din, init_pin_i, done_reprogram_pin_i,
                      mode_sel_0, mode_sel_1, mode_sel_2, cfg_data};
            s2_ff <= s1_ff;
            lclk_prev_ff <= s2_ff[14];
        end
    end
    logic rise, fall, din_s, init_s, done_s;
    logic [2:0] mode_s;
    logic [7:0] data_s;
    assign rise = s2_ff[14] & ~lclk_prev_ff;
    assign fall = ~s2_ff[14] & lclk_prev_ff;
    assign din_s = s2_ff[13];
    assign init_s = s2_ff[12];
    assign done_s = s2_ff[11];
    assign mode_s = s2_ff[10:8];
    assign data_s = s2_ff[7:0];

    bcl_state_e state_ff, nxt_state;
    logic [`BCL_CTRL_W-1:0] ctrl_ff;
    logic [2:0] mode_ff;
    logic [`BCL_LEN_W-1:0] cnt_ff, len_ff;
    logic [`BCL_PRE_W-1:0] pre_ff;
    logic [4:0] lbit_ff;
    logic [FBW-1:0] fbit_ff;
    logic [AW-1:0] fidx_ff;
    logic [W-1:0] word_ff;
    logic [2:0] bcnt_ff, su_ff;
    logic [7:0] bsh_ff;
    logic [31:0] wsel_ff;
    logic wr_ff, cap_ff, pass_ff, done_ff, pready_ff;
    logic apb_acc, wr_acc, start_req, mode_ok, bit_in, frame_err, loading, count_hit;
    logic [2:0] idx;

    assign idx = reg_idx(paddr);
    assign apb_acc = psel & penable & pready_ff;
    assign wr_acc = apb_acc & pwrite;
    assign start_req = wr_acc && idx == 3'h0 && pwdata[`BCL_CTRL_START];
    assign mode_ok = (mode_s == `BCL_MODE_MSER) || (mode_s == `BCL_MODE_SSER)
                     || is_byte_mode(mode_s);
    // byte modes take msb of each byte first
    assign bit_in = !is_byte_mode(mode_ff) ? din_s
                    : (bcnt_ff == 3'h0) ? data_s[7] : bsh_ff[7];
    assign frame_err = (fbit_ff == '0 && bit_in) || (fbit_ff >= FB_STOP && !bit_in);
    assign loading = (state_ff == BCL_PRE) || (state_ff == BCL_LEN) || (state_ff == BCL_FRM)
                     || (state_ff == BCL_PASS) || (state_ff == BCL_SU);
    assign count_hit = (cnt_ff + 24'h1) == len_ff;

    always_comb begin
        nxt_state = state_ff;
        if (start_req) begin
            nxt_state = mode_ok ? BCL_PRE : BCL_ERR;
        end else if (rise) begin
            case (state_ff)
                BCL_PRE: begin
                    if ({pre_ff[`BCL_PRE_W-2:0], bit_in} == `BCL_PRE_CODE) begin
                        nxt_state = BCL_LEN;
                    end
                end
                BCL_LEN: begin
                    if (lbit_ff == 5'(`BCL_LEN_W - 1)) begin
                        nxt_state = BCL_FRM;
                    end
                end
                BCL_FRM: begin
                    if (frame_err) begin
                        nxt_state = BCL_ERR;
                    end else if (fbit_ff == FB_LAST && fidx_ff == FI_LAST) begin
                        nxt_state = count_hit ? BCL_SU : BCL_PASS;
                    end
                end
                BCL_PASS: begin
                    if (count_hit) begin
                        nxt_state = BCL_SU;
                    end
                end
                BCL_SU: begin
                    if (su_ff + 3'h1 == SU_END) begin
                        nxt_state = BCL_RUN;
                    end
                end
                default: nxt_state = state_ff;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= BCL_IDLE;
            mode_ff <= `BCL_MODE_MSER;
        end else begin
            state_ff <= nxt_state;
            if (start_req) begin
                mode_ff <= mode_s;
            end
        end
    end

    // clock counter and header parsing
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= '0;
            pre_ff <= '0;
            len_ff <= '0;
            lbit_ff <= '0;
        end else if (start_req) begin
            cnt_ff <= '0;
            pre_ff <= '0;
            len_ff <= '0;
            lbit_ff <= '0;
        end else if (rise && loading) begin
            cnt_ff <= cnt_ff + 24'h1;
            if (state_ff == BCL_PRE) begin
                pre_ff <= {pre_ff[`BCL_PRE_W-2:0], bit_in};
            end
            if (state_ff == BCL_LEN) begin
                len_ff <= {len_ff[`BCL_LEN_W-2:0], bit_in};
                lbit_ff <= lbit_ff + 5'h1;
            end
        end
    end

    // frame assembly; a word is written only after its stop bits check out
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fbit_ff <= '0;
            fidx_ff <= '0;
            word_ff <= '0;
            wr_ff <= 1'b0;
        end else begin
            wr_ff <= 1'b0;
            if (start_req) begin
                fbit_ff <= '0;
                fidx_ff <= '0;
            end else if (rise && state_ff == BCL_FRM) begin
                if (fbit_ff >= FBW'(1) && fbit_ff <= FB_DLAST) begin
                    word_ff <= {word_ff[W-2:0], bit_in};
                end
                if (fbit_ff == FB_LAST) begin
                    fbit_ff <= '0;
                    wr_ff <= !frame_err;
                end else begin
                    fbit_ff <= fbit_ff + FBW'(1);
                end
            end
            if (wr_ff) begin
                fidx_ff <= fidx_ff + AW'(1);
            end
        end
    end
    assign mem_port.wr_en = wr_ff;
    assign mem_port.wr_addr = fidx_ff;
    assign mem_port.wr_data = word_ff;
    assign mem_port.rd_addr = wsel_ff[AW-1:0];

    // byte serializer and prom address for the byte-wide modes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bcnt_ff <= '0;
            bsh_ff <= '0;
            prom_addr <= `BCL_ADDR_UP_START;
        end else if (start_req) begin
            bcnt_ff <= '0;
            prom_addr <= (mode_s == `BCL_MODE_MDN) ? `BCL_ADDR_DN_START
                                                   : `BCL_ADDR_UP_START;
        end else if (rise && loading && is_byte_mode(mode_ff)) begin
            bcnt_ff <= bcnt_ff + 3'h1;
            if (bcnt_ff == 3'h0) begin
                bsh_ff <= {data_s[6:0], 1'b0};
                prom_addr <= (mode_ff == `BCL_MODE_MDN) ? prom_addr - 16'h1
                                                        : prom_addr + 16'h1;
            end else begin
                bsh_ff <= {bsh_ff[6:0], 1'b0};
            end
        end
    end

    // chain output: header and surplus data forwarded, own frames give a high
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cap_ff <= 1'b1;
            pass_ff <= 1'b0;
            cfg_dout <= 1'b1;
        end else begin
            if (rise) begin
                cap_ff <= bit_in;
                pass_ff <= (state_ff == BCL_PRE) || (state_ff == BCL_LEN)
                           || (state_ff == BCL_PASS);
            end
            if (fall) begin
                cfg_dout <= pass_ff ? cap_ff : 1'b1;
            end
        end
    end

    // start-up sequence, counted in link clocks from completion
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            su_ff <= '0;
            io_enable <= 1'b0;
            user_rst_n <= 1'b0;
            done_ff <= 1'b0;
            done_reprogram_pin_oe <= 1'b1;
            cmos_threshold <= 1'b0;
            osc_connect <= 1'b0;
        end else if (start_req) begin
            io_enable <= 1'b0;
            user_rst_n <= 1'b0;
            done_ff <= 1'b0;
            done_reprogram_pin_oe <= 1'b1;
            cmos_threshold <= 1'b0;
            osc_connect <= 1'b0;
        end else if (rise) begin
            if (nxt_state == BCL_SU && state_ff != BCL_SU) begin
                su_ff <= '0;
                cmos_threshold <= ctrl_ff[`BCL_CTRL_CMOS];
                osc_connect <= ctrl_ff[`BCL_CTRL_OSC];
            end else if (state_ff == BCL_SU) begin
                su_ff <= su_ff + 3'h1;
                if (su_ff + 3'h1 == `BCL_SU_IO) begin
                    io_enable <= 1'b1;
                end
                if (su_ff + 3'h1 == (ctrl_ff[`BCL_CTRL_RST_LATE] ? `BCL_SU_LATE
                                                                 : `BCL_SU_EARLY)) begin
                    user_rst_n <= 1'b1;
                end
                if (su_ff + 3'h1 == (ctrl_ff[`BCL_CTRL_DONE_LATE] ? `BCL_SU_LATE
                                                                  : `BCL_SU_EARLY)) begin
                    done_ff <= 1'b1;
                    // released with done itself, not a clock behind the config pins
                    done_reprogram_pin_oe <= 1'b0;
                end
            end
        end
    end

    // configuration pins and open-drain outputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            high_during_cfg_oe <= 1'b1;
            low_during_cfg_oe <= 1'b1;
            done_pullup_en <= 1'b0;
            init_pin_oe <= 1'b0;
            osc_run <= 1'b0;
        end else begin
            high_during_cfg_oe <= nxt_state != BCL_RUN;
            low_during_cfg_oe <= nxt_state != BCL_RUN;
            done_pullup_en <= ctrl_ff[`BCL_CTRL_PULLUP];
            init_pin_oe <= nxt_state == BCL_ERR;
            if (start_req) begin
                osc_run <= pwdata[`BCL_CTRL_OSC];
            end
        end
    end
    // levels of the driven pins are fixed; only the enables move
    assign high_during_cfg_o = 1'b1;
    assign low_during_cfg_o = 1'b0;
    assign done_reprogram_pin_o = 1'b0;
    assign init_pin_o = 1'b0;

    // apb slave: one wait state on every access
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff <= `BCL_CTRL_RESET;
            wsel_ff <= '0;
        end else if (wr_acc) begin
            if (idx == 3'h0) begin
                ctrl_ff <= pwdata[`BCL_CTRL_W-1:0] & ~(`BCL_CTRL_W'(1) << `BCL_CTRL_START);
            end else if (idx == 3'h4) begin
                wsel_ff <= pwdata;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready_ff <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready_ff <= psel & penable & ~pready_ff;
            pslverr <= psel & penable & ~pready_ff & (idx == 3'h7);
            prdata <= '0;
            if (psel && penable && !pready_ff && !pwrite) begin
                if (idx == 3'h0) begin
                    prdata <= 32'(ctrl_ff);
                end else if (idx == 3'h1) begin
                    prdata <= {18'h0, done_s, init_s, done_ff, mode_ff, state_ff};
                end else if (idx == 3'h2) begin
                    prdata <= 32'(cnt_ff);
                end else if (idx == 3'h3) begin
                    prdata <= 32'(len_ff);
                end else if (idx == 3'h4) begin
                    prdata <= wsel_ff;
                end else if (idx == 3'h5) begin
                    prdata <= mem_port.rd_data[31:0];
                end
            end
        end
    end
    assign pready = pready_ff;
endmodule

// file: tb/bcl_loader_props.sv
// start-up and pin-drive assertions for the configuration loader
module bcl_loader_props (
    input wire logic clk,
    input wire logic nrst,
    input wire logic high_during_cfg_o,
    input wire logic high_during_cfg_oe,
    input wire logic low_during_cfg_o,
    input wire logic low_during_cfg_oe,
    input wire logic done_reprogram_pin_oe,
    input wire logic init_pin_oe,
    input wire logic user_rst_n,
    input wire logic io_enable,
    input wire logic cmos_threshold,
    input wire logic osc_run,
    input wire logic osc_connect
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // one link clock is 16 clk, so 24 gives sync slack
    a_pin_levels: assert property (high_during_cfg_o && !low_during_cfg_o)
        else $error("configuration pin levels wrong");
    a_pins_until_io: assert property (!io_enable |-> high_during_cfg_oe && low_during_cfg_oe)
        else $error("configuration pins released early");
    a_rst_after_io: assert property ($rose(io_enable) |-> ##[0:24] user_rst_n)
        else $error("user reset not released near io enable");
    a_io_after_rst: assert property ($rose(user_rst_n) |-> ##[0:24] io_enable)
        else $error("user reset released too early");
    a_done_near_io: assert property ($fell(done_reprogram_pin_oe) |-> ##[0:24] io_enable)
        else $error("done not near io enable");
    a_run_released: assert property ($fell(high_during_cfg_oe) |->
        user_rst_n && io_enable && !done_reprogram_pin_oe)
        else $error("pins released before start-up end");
    a_cmos_at_end: assert property ($rose(cmos_threshold) |-> !io_enable ##[24:40] io_enable)
        else $error("threshold switch not at completion");
    a_osc_late: assert property ($rose(osc_connect) |-> osc_run && !io_enable)
        else $error("oscillator connect out of order");
    a_error_holds: assert property (init_pin_oe |->
        !io_enable && !user_rst_n && done_reprogram_pin_oe)
        else $error("start-up after configuration error");
endmodule
bind bcl_loader bcl_loader_props u_props (.clk, .nrst, .high_during_cfg_o, .high_during_cfg_oe,
    .low_during_cfg_o, .low_during_cfg_oe, .done_reprogram_pin_oe, .init_pin_oe, .user_rst_n,
    .io_enable, .cmos_threshold, .osc_run, .osc_connect);

// file: tb/bcl_stream_src.sv
// far-side source of the serial configuration stream
module bcl_stream_src #(
    parameter int FLEN = 40,
    parameter int FCNT = 4
) (
    output logic cfg_clock,
    output logic cfg_din,
    output int n_edges
);
    timeunit 1ns;
    timeprecision 100ps;
    logic bits[$];
    logic [3:0] code = 4'h2;
    initial begin
        cfg_clock = 1'b0;
        cfg_din = 1'b1;
        n_edges = 0;
    end
    task automatic build(input logic [23:0] len, input int extra, input bit bad);
        bits = {};
        repeat (8) bits.push_back(1'b1);
        for (int i = 3; i >= 0; i--) bits.push_back(code[i]);
        for (int i = 23; i >= 0; i--) bits.push_back(len[i]);
        for (int f = 0; f < FCNT; f++) begin
            bits.push_back(1'b0);
            for (int j = 0; j < FLEN - 4; j++) bits.push_back((f * 5 + j) % 3 == 0);
            bits.push_back(1'b1);
            bits.push_back(1'b1);
            bits.push_back(!(bad && f == 1));
        end
        while (bits.size() < len + extra) bits.push_back(bits.size() % 3 == 1);
    endtask
    task automatic play();
        n_edges = 0;
        #1.3;
        foreach (bits[i]) begin
            cfg_din = bits[i];
            #40;
            cfg_clock = 1'b1;
            n_edges++;
            #40;
            cfg_clock = 1'b0;
        end
        // line inverted after the last bit: no stale value left behind
        cfg_din = ~cfg_din;
    endtask
endmodule

// file: tb/bcl_loader_test.sv
// self-checking bench for the configuration loader
`include "bcl_map.svh"
module bcl_loader_test;
    timeunit 1ns;
    timeprecision 100ps;
    import bcl_pkg::*;
    localparam int FLEN = 40;
    localparam int FCNT = 4;
    localparam int KC = 2;
    localparam int HDR = 36;
    function automatic int lc(input int k);
        int tot;
        int up;
        tot = 40 + FLEN * FCNT + 4 + 1;
        up = (8 - tot % 8) % 8;
        return tot + up - k + ((up < k) ? 8 : 0);
    endfunction
    localparam int LEN = lc(KC);
    logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, mon_on = 0;
    bcl_addr_t paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdat;
    logic pready, pslverr, rerr, cfg_clock, cfg_din, cfg_dout;
    logic [7:0] cfg_data = '0;
    logic mode_sel_0 = 0, mode_sel_1 = 0, mode_sel_2 = 0;
    logic [15:0] prom_addr;
    logic high_during_cfg_o, high_during_cfg_oe, low_during_cfg_o, low_during_cfg_oe;
    logic done_reprogram_pin_i, done_reprogram_pin_o, done_reprogram_pin_oe, done_pullup_en;
    logic init_pin_i, init_pin_o, init_pin_oe, user_rst_n, io_enable;
    logic cmos_threshold, osc_run, osc_connect;
    int n_mismatch = 0, comparisons = 0, n_edges, mon_e = 0, io_at, rst_at, done_at;
    // open-drain pins with pull-ups
    assign done_reprogram_pin_i = !done_reprogram_pin_oe;
    assign init_pin_i = !init_pin_oe;
    always #2.5 clk = ~clk;
    bcl_loader #(.FRAME_LEN(FLEN), .FRAME_CNT(FCNT), .K(KC)) dut (
        .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .cfg_clock, .cfg_din, .cfg_data, .mode_sel_0, .mode_sel_1, .mode_sel_2, .cfg_dout,
        .prom_addr, .high_during_cfg_o, .high_during_cfg_oe, .low_during_cfg_o,
        .low_during_cfg_oe, .done_reprogram_pin_i, .done_reprogram_pin_o,
        .done_reprogram_pin_oe, .done_pullup_en, .init_pin_i, .init_pin_o, .init_pin_oe,
        .user_rst_n, .io_enable, .cmos_threshold, .osc_run, .osc_connect);
    bcl_stream_src #(.FLEN(FLEN), .FCNT(FCNT)) src (.cfg_clock, .cfg_din, .n_edges);
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input bcl_addr_t a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk("pready", 32'h0, 32'h1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic do_reset;
        nrst <= 1'b0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
    endtask
    // frame bits stay inside; header and surplus bits go on down the chain
    always @(posedge cfg_clock) begin
        mon_e++;
        if (mon_on && mon_e >= 2 && mon_e <= LEN) begin
            if (mon_e - 2 >= HDR && mon_e - 2 < HDR + FLEN * FCNT)
                chk("dout frame", 32'(cfg_dout), 32'h1);
            else
                chk("dout pass", 32'(cfg_dout), 32'(src.bits[mon_e - 2]));
        end
    end
    always @(posedge io_enable) io_at = n_edges;
    always @(posedge user_rst_n) rst_at = n_edges;
    always @(negedge done_reprogram_pin_oe) done_at = n_edges;
    task automatic run_cfg(input logic [31:0] ctrl, input bit bad);
        logic [31:0] exp;
        do_reset;
        {mode_sel_0, mode_sel_1, mode_sel_2} <= 3'h7;
        io_at = 0;
        rst_at = 0;
        done_at = 0;
        src.build(LEN[23:0], 4, bad);
        repeat (4) @(posedge clk);
        apb(1'b1, `BCL_OFF_CTRL, ctrl | 32'h1);
        apb(1'b0, `BCL_OFF_COUNT, 32'h0);
        chk("count", rdat, 32'h0);
        chk("osc run", 32'(osc_run), 32'(ctrl[5]));
        chk("pin levels", 32'({low_during_cfg_oe, low_during_cfg_o, done_reprogram_pin_o,
            init_pin_o}), 32'h8);
        mon_e = 0;
        mon_on = !bad;
        src.play();
        mon_on = 0;
        repeat (12) @(posedge clk);
        apb(1'b0, `BCL_OFF_STATUS, 32'h0);
        if (bad) begin
            chk("status", 32'(rdat[13:0]), 32'h0780);
            chk("init oe", 32'(init_pin_oe), 32'h1);
        end else begin
            chk("status", 32'(rdat[13:0]), 32'h3f40);
            chk("io at", io_at, LEN + 2);
            chk("rst at", rst_at, LEN + (ctrl[1] ? 3 : 1));
            chk("done at", done_at, LEN + (ctrl[2] ? 3 : 1));
            chk("pins", 32'({high_during_cfg_oe, low_during_cfg_oe, done_pullup_en,
                cmos_threshold, osc_connect}), 32'({2'b00, ctrl[3], ctrl[4], ctrl[5]}));
            apb(1'b0, `BCL_OFF_LENGTH, 32'h0);
            chk("length", rdat, LEN);
            for (int f = 0; f < FCNT; f++) begin
                apb(1'b1, `BCL_OFF_WSEL, f);
                apb(1'b0, `BCL_OFF_WDATA, 32'h0);
                exp = '0;
                for (int j = 4; j < FLEN - 4; j++) exp[FLEN - 5 - j] = src.bits[HDR + f * FLEN + 1 + j];
                chk("word", rdat, exp);
            end
        end
        $display("test load ctrl %h bad %0d done", ctrl, bad);
    endtask
    initial begin
        #200000;
        n_mismatch++;
        end_sim;
    end
    initial begin
        do_reset;
        apb(1'b0, `BCL_OFF_CTRL, 32'h0);
        chk("ctrl reset", rdat, 32'(`BCL_CTRL_RESET));
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped err", 32'(rerr), 32'h1);
        chk("unmapped data", rdat, 32'h0);
        apb(1'b1, `BCL_OFF_STATUS, 32'hffff_ffff);
        apb(1'b1, `BCL_OFF_CTRL, 32'hffff_fffe);
        apb(1'b0, `BCL_OFF_CTRL, 32'h0);
        chk("ctrl rw", rdat, 32'h3e);
        chk("ttl default", 32'(cmos_threshold), 32'h0);
        apb(1'b0, `BCL_OFF_STATUS, 32'h0);
        chk("status idle", 32'(rdat[7:0]), 32'h01);
        $display("test registers done");
        for (int m = 0; m < 8; m++) begin
            do_reset;
            {mode_sel_0, mode_sel_1, mode_sel_2} <= 3'(m);
            repeat (4) @(posedge clk);
            apb(1'b1, `BCL_OFF_CTRL, 32'h1);
            apb(1'b0, `BCL_OFF_STATUS, 32'h0);
            chk("mode", 32'(rdat[10:0]), {21'h0, 3'(m), (m inside {2, 4, 6}) ? 8'h80 : 8'h02});
            chk("prom addr", 32'(prom_addr), (m == 3) ? 32'hffff : 32'h0);
        end
        $display("test modes done");
        run_cfg(32'h0, 1'b0);
        run_cfg(32'h3e, 1'b0);
        run_cfg(32'h2a, 1'b0);
        run_cfg(32'h0, 1'b1);
        end_sim;
    end
endmodule
